//--- common/psl_pkg.sv
// Purpose: constants for the serial programming latches of the synthesizer
// Assumes: 18-bit words, 2-bit address in the lowest positions
// Notes:   field positions are bit indices within the shifted word
package psl_pkg;
  localparam int WORD_W        = 18;
  localparam int DATA_W        = 16;
  localparam int ADDR_W        = 2;
  localparam int REF_DIV_W     = 12;
  localparam int PROG_W        = 12;
  localparam int SWAL_W        = 4;
  localparam int SEL_W         = 4;
  localparam int PUMP_W        = 4;
  localparam int SYNC_STAGES   = 2;
  // latch addresses
  localparam logic [1:0] ADDR_AUX_REF   = 2'h0;
  localparam logic [1:0] ADDR_AUX_FB    = 2'h1;
  localparam logic [1:0] ADDR_MAIN_REF  = 2'h2;
  localparam logic [1:0] ADDR_MAIN_FB   = 2'h3;
  // field positions in the word
  localparam int ADDR_LSB      = 0;
  localparam int DATA_LSB      = 2;
  localparam int SEL_LSB       = 14;
  localparam int REF_LSB       = 2;
  localparam int PROG_LSB      = 6;
  localparam int SWAL_LSB      = 2;
  localparam int PUMP_LSB      = 14;
  // pump control word bit positions within the 4-bit field
  localparam int AUX_GAIN_BIT  = 3;
  localparam int MAIN_GAIN_BIT = 2;
  localparam int AUX_POL_BIT   = 1;
  localparam int MAIN_POL_BIT  = 0;
  // prescaler moduli
  localparam logic [5:0] MOD_HIGH = 6'h10;
  localparam logic [5:0] MOD_LOW  = 6'h08;
  // values after reset of the holding latches and the shift register
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [17:0] SHIFT_RESET = 18'h00000;
  typedef enum logic [1:0] {PSL_ADDR_AR, PSL_ADDR_AF, PSL_ADDR_MR,
                            PSL_ADDR_MF} psl_addr_e;
endpackage

//--- logic/psl_latches.sv
// Purpose: serial programming port and four holding latches
// Assumes: serial clock and latch strobe come from the host; the shift
//          register runs on the serial clock as a second domain
// Notes:   decoded fields are presented on sys_clk outputs four to six
//          sys_clk cycles after the strobe edge
//
// Functional notes
// RULE_01: word is 16-bit payload plus 2-bit address
// RULE_02: host sends most significant bit first
// RULE_03: latch strobe rise copies word into one latch
// RULE_04: address 00,01,10,11 picks aux/main latches
// RULE_05: aux reference: select 17:14, divide 13:2
// RULE_06: select field drives multifunction output choice
// RULE_07: host keeps reference divide in 2..4095
// RULE_08: main reference latch holds divide and controls
// RULE_09: pump word sets gains and polarities
// RULE_10: aux feedback: program 17:6, swallow 5:2
// RULE_11: host keeps aux feedback ratio in range
// RULE_12: high option swallow count is 0..15
// RULE_13: low option ignores swallow top bit
// RULE_14: main feedback latch sets 16-bit divider
// RULE_15: feedback ratio is modulus times B plus A
// RULE_16: pump bits 17..14 gain and polarity
// RULE_17: data sampled on serial clock rising edge
// RULE_18: only last eighteen bits are transferred
`timescale 1ns/1ps
`default_nettype none
module psl_latches
  import psl_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_data,
  input  wire logic                 latch_strobe,
  input  wire logic                 aux_low_option,
  output var  logic [SEL_W-1:0]     multifunction_output_select,
  output var  logic [REF_DIV_W-1:0] aux_reference_divide,
  output var  logic [PROG_W-1:0]    aux_program_count,
  output var  logic [SWAL_W-1:0]    aux_swallow_count,
  output var  logic [DATA_W-1:0]    aux_feedback_divide,
  output var  logic [REF_DIV_W-1:0] main_reference_divide,
  output var  logic [PUMP_W-1:0]    pump_control_word,
  output var  logic                 aux_pump_gain_bit,
  output var  logic                 main_pump_gain_bit,
  output var  logic                 aux_detector_polarity_bit,
  output var  logic                 main_detector_polarity_bit,
  output var  logic [PROG_W-1:0]    main_program_count,
  output var  logic [SWAL_W-1:0]    main_swallow_count,
  output var  logic [DATA_W-1:0]    main_feedback_divide,
  output var  logic [3:0]           load_count
);

  // -----------------------------------------------------------------
  // link domain: shift register
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] shift;
  } psl_shift_s;
  typedef struct packed {
    logic [DATA_W-1:0] lat_ar;
    logic [DATA_W-1:0] lat_af;
    logic [DATA_W-1:0] lat_mr;
    logic [DATA_W-1:0] lat_mf;
    logic [3:0]        tog;
  } psl_latch_s;

  function automatic logic [3:0] addr_onehot(input logic [1:0] a);
    logic [3:0] r;
    r = 4'h0;
    r[a] = 1'b1;
    return r;
  endfunction

  psl_shift_s sh;
  psl_shift_s next_sh;
  psl_latch_s lt;
  psl_latch_s next_lt;

  // there is no reset on the pins; the system reset clears these
  always_comb begin
    next_sh = sh;
    next_sh.shift = {sh.shift[WORD_W-2:0], serial_data}; // RULE_17 RULE_18
  end

  always_ff @(posedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      sh <= SHIFT_RESET;
    end else begin
      sh <= next_sh;
    end
  end

  // -----------------------------------------------------------------
  // strobe domain: holding latches
  // -----------------------------------------------------------------
  // the strobe edge itself clocks the load, so no sampling clock has
  // to be fast enough to see it; a toggle per latch announces a load.
  // the shift register is not synchronised: a serial clock edge close
  // to the strobe edge would latch a half-shifted word
  logic [3:0] sel;
  always_comb begin
    sel = addr_onehot(sh.shift[ADDR_LSB +: ADDR_W]); // RULE_04
    next_lt = lt;
    if (sel[ADDR_AUX_REF]) begin
      next_lt.lat_ar = sh.shift[DATA_LSB +: DATA_W]; // RULE_03 RULE_01
    end
    if (sel[ADDR_AUX_FB]) begin
      next_lt.lat_af = sh.shift[DATA_LSB +: DATA_W];
    end
    if (sel[ADDR_MAIN_REF]) begin
      next_lt.lat_mr = sh.shift[DATA_LSB +: DATA_W]; // RULE_08
    end
    if (sel[ADDR_MAIN_FB]) begin
      next_lt.lat_mf = sh.shift[DATA_LSB +: DATA_W]; // RULE_14
    end
    next_lt.tog = lt.tog ^ sel;
  end

  always_ff @(posedge latch_strobe or negedge resetn) begin
    if (!resetn) begin
      lt <= '0;
    end else begin
      lt <= next_lt;
    end
  end

  // -----------------------------------------------------------------
  // crossing into sys_clk
  // -----------------------------------------------------------------
  // latch contents are stable long before their toggle is seen, so
  // data passes two flops and is taken only after the toggle arrives
  logic [4*DATA_W+3:0] sync_out;
  psl_sync #(.W(4*DATA_W+4)) u_sync (
    .clk    (sys_clk),
    .resetn (resetn),
    .din    ({lt.lat_ar, lt.lat_af, lt.lat_mr, lt.lat_mf, lt.tog}),
    .dout   (sync_out)
  );

  logic opt_sync;
  psl_sync #(.W(1)) u_opt (
    .clk    (sys_clk),
    .resetn (resetn),
    .din    (aux_low_option),
    .dout   (opt_sync)
  );

  // -----------------------------------------------------------------
  // system domain: captured copies and decoded fields
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        tog_seen;
    logic [3:0]        pend;
    logic [DATA_W-1:0] ar;
    logic [DATA_W-1:0] af;
    logic [DATA_W-1:0] mr;
    logic [DATA_W-1:0] mf;
    logic [SEL_W-1:0]     fsel;
    logic [REF_DIV_W-1:0] aref;
    logic [PROG_W-1:0]    aprog;
    logic [SWAL_W-1:0]    aswal;
    logic [DATA_W-1:0]    afb;
    logic [REF_DIV_W-1:0] mref;
    logic [PUMP_W-1:0]    pump;
    logic [PROG_W-1:0]    mprog;
    logic [SWAL_W-1:0]    mswal;
    logic [DATA_W-1:0]    mfb;
    logic [3:0]           loads;
  } psl_sys_s;

  psl_sys_s ss;
  psl_sys_s next_ss;

  logic [DATA_W-1:0] s_ar, s_af, s_mr, s_mf;
  logic [3:0]        s_tog;
  assign {s_ar, s_af, s_mr, s_mf, s_tog} = sync_out;

  // -----------------------------------------------------------------
  // system domain: field pickers
  // -----------------------------------------------------------------
  // pickers take a 16-bit latch; offsets are word positions less the
  // two address bits, which the latches do not keep
  function automatic logic [SEL_W-1:0] top_field(
    input logic [DATA_W-1:0] w);
    return w[SEL_LSB-DATA_LSB +: SEL_W];
  endfunction

  function automatic logic [REF_DIV_W-1:0] ref_field(
    input logic [DATA_W-1:0] w);
    return w[REF_LSB-DATA_LSB +: REF_DIV_W];
  endfunction

  function automatic logic [PROG_W-1:0] prog_field(
    input logic [DATA_W-1:0] w);
    return w[PROG_LSB-DATA_LSB +: PROG_W];
  endfunction

  function automatic logic [SWAL_W-1:0] swal_field(
    input logic [DATA_W-1:0] w);
    return w[SWAL_LSB-DATA_LSB +: SWAL_W];
  endfunction

  // feedback ratio: modulus times program count plus swallow count;
  // 22 bits hold the widest product, and the host keeps N in 16 bits
  function automatic logic [DATA_W-1:0] fb_ratio(
    input logic [PROG_W-1:0] b,
    input logic [SWAL_W-1:0] a,
    input logic [5:0]        p);
    logic [21:0] n;
    n = 22'(b) * 22'(p) + 22'(a);
    return n[DATA_W-1:0];
  endfunction

  // more than one latch may land inside one crossing window
  function automatic logic [3:0] count_loads(input logic [3:0] p);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 4; i++) begin
      c = c + {3'h0, p[i]};
    end
    return c;
  endfunction

  // -----------------------------------------------------------------
  // system domain: capture and decode
  // -----------------------------------------------------------------
  logic [SWAL_W-1:0] aux_a;
  logic [5:0]        aux_p;

  always_comb begin
    next_ss = ss;
    // wait one cycle after a toggle edge so the data bits have settled
    // (the data bits cross beside the toggle with no handshake)
    next_ss.tog_seen = s_tog;
    next_ss.pend = s_tog ^ ss.tog_seen;
    if (ss.pend[ADDR_AUX_REF]) begin
      next_ss.ar = s_ar;
    end
    if (ss.pend[ADDR_AUX_FB]) begin
      next_ss.af = s_af;
    end
    if (ss.pend[ADDR_MAIN_REF]) begin
      next_ss.mr = s_mr;
    end
    if (ss.pend[ADDR_MAIN_FB]) begin
      next_ss.mf = s_mf;
    end
    next_ss.loads = ss.loads + count_loads(ss.pend);
    // aux reference: select in word 17:14, divide in 13:2
    next_ss.fsel = top_field(ss.ar); // RULE_05 RULE_06
    next_ss.aref = ref_field(ss.ar); // RULE_05
    // aux feedback: program in 17:6, swallow in 5:2
    next_ss.aprog = prog_field(ss.af); // RULE_10
    aux_a = swal_field(ss.af); // RULE_12
    aux_p = MOD_HIGH;
    if (opt_sync) begin
      aux_a[SWAL_W-1] = 1'b0; // RULE_13
      aux_p = MOD_LOW;
    end
    next_ss.aswal = aux_a;
    next_ss.afb = fb_ratio(prog_field(ss.af), aux_a, aux_p); // RULE_15
    next_ss.mref = ref_field(ss.mr); // RULE_08
    next_ss.pump = ss.mr[PUMP_LSB-DATA_LSB +: PUMP_W]; // RULE_09 RULE_16
    next_ss.mprog = prog_field(ss.mf); // RULE_14
    next_ss.mswal = swal_field(ss.mf);
    next_ss.mfb = fb_ratio(prog_field(ss.mf), swal_field(ss.mf),
                           MOD_HIGH); // RULE_15
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ss <= '0;
    end else begin
      ss <= next_ss;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all from sys_clk flops
  // -----------------------------------------------------------------
  assign multifunction_output_select = ss.fsel;
  assign aux_reference_divide        = ss.aref;
  assign aux_program_count           = ss.aprog;
  assign aux_swallow_count           = ss.aswal;
  assign aux_feedback_divide         = ss.afb;

  // -----------------------------------------------------------------
  // outputs of the main loop and the pump word
  // -----------------------------------------------------------------
  assign main_reference_divide       = ss.mref;
  assign pump_control_word           = ss.pump;
  assign aux_pump_gain_bit           = ss.pump[AUX_GAIN_BIT]; // RULE_16
  assign main_pump_gain_bit          = ss.pump[MAIN_GAIN_BIT];
  assign aux_detector_polarity_bit   = ss.pump[AUX_POL_BIT];
  assign main_detector_polarity_bit  = ss.pump[MAIN_POL_BIT];
  assign main_program_count          = ss.mprog;
  assign main_swallow_count          = ss.mswal;
  assign main_feedback_divide        = ss.mfb;

  // -----------------------------------------------------------------
  // load counter
  // -----------------------------------------------------------------
  // wraps silently; a watcher compares it before and after a load
  assign load_count                  = ss.loads;
endmodule
`default_nettype wire

//--- logic/psl_sync.sv
// Purpose: two-stage synchroniser carrying a bus into sys_clk
// Assumes: the source changes rarely and only after a toggle event
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module psl_sync
  import psl_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } psl_sync_s;
  psl_sync_s st;
  psl_sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule
`default_nettype wire

//--- sim/psl_host.sv
// Purpose: host side of the three-wire programming port
// Assumes: caller waits for send to return before the next word
// Notes:   serial clock stands still between words
`timescale 1ns/1ps
`default_nettype none
module psl_host (
  output var logic serial_clk,
  output var logic serial_data,
  output var logic latch_strobe
);
  initial begin
    serial_clk = 0;
    serial_data = 0;
    latch_strobe = 0;
  end
  // leading bits beyond 18 must fall out of the shifter
  task automatic send(input logic [21:0] v, input int n);
    #13;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = v[i];
      #80 serial_clk = 1;
      #80 serial_clk = 0;
    end
    #40 latch_strobe = 1;
    #80 latch_strobe = 0;
    // data held until the outputs have settled, then made stale
    #200 serial_data = ~serial_data;
  endtask
endmodule
`default_nettype wire

//--- sim/psl_latches_properties.sv
// Purpose: timing and field checks on the programming latches
// Assumes: strobe pulses are longer than one sys_clk period
// Notes:   loads land a few sys_clk cycles after the strobe edge
`timescale 1ns/1ps
`default_nettype none
module psl_chk
  import psl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        latch_strobe,
  input wire logic [11:0] aux_reference_divide,
  input wire logic [11:0] main_reference_divide,
  input wire logic [11:0] main_program_count,
  input wire logic [3:0]  main_swallow_count,
  input wire logic [15:0] main_feedback_divide,
  input wire logic [3:0]  pump_control_word,
  input wire logic        aux_pump_gain_bit,
  input wire logic        main_pump_gain_bit,
  input wire logic        aux_detector_polarity_bit,
  input wire logic        main_detector_polarity_bit,
  input wire logic [3:0]  load_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // cycles since the strobe was last seen high, saturating
  logic [3:0] age;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) age <= 4'hf;
    else if (latch_strobe) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  sequence s_strobe;
    $rose(latch_strobe);
  endsequence
  sequence s_counts_still;
    ($stable(main_program_count) && $stable(main_swallow_count)) [*3];
  endsequence
  a_load_follows: assert property (s_strobe |-> ##[2:8] $changed(load_count))
    else $error("no load after strobe");
  a_count_quiet: assert property ($changed(load_count) |-> age < 4'h8)
    else $error("load without strobe");
  a_aref_quiet: assert property ($changed(aux_reference_divide) |-> age < 4'h8)
    else $error("aux reference moved without strobe");
  a_mref_quiet: assert property ($changed(main_reference_divide) |-> age < 4'h8)
    else $error("main reference moved without strobe");
  a_aux_gain: assert property (aux_pump_gain_bit == pump_control_word[AUX_GAIN_BIT])
    else $error("aux gain bit mismatch");
  a_main_gain: assert property (main_pump_gain_bit == pump_control_word[MAIN_GAIN_BIT])
    else $error("main gain bit mismatch");
  a_aux_pol: assert property (aux_detector_polarity_bit == pump_control_word[AUX_POL_BIT])
    else $error("aux polarity bit mismatch");
  a_main_pol: assert property (main_detector_polarity_bit == pump_control_word[MAIN_POL_BIT])
    else $error("main polarity bit mismatch");
  a_main_ratio: assert property (s_counts_still |->
    main_feedback_divide == {main_program_count, 4'h0} + {12'h0, main_swallow_count})
    else $error("main divide ratio wrong");
endmodule
bind psl_latches psl_chk u_chk (.*);
`default_nettype wire

//--- sim/test_pll_serial_program_latches.sv
// Purpose: self-checking bench for the programming latches
// Assumes: host model drives the serial lines, 160 ns serial clock
// Notes:   shadow latches give the expected outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_pll_serial_program_latches;
  import psl_pkg::*;
  logic        sys_clk = 0, aux_low_option = 0;
  logic        resetn;
  wire logic   serial_clk, serial_data, latch_strobe;
  logic [3:0]  multifunction_output_select, aux_swallow_count;
  logic [3:0]  pump_control_word, main_swallow_count, load_count, loads;
  logic [11:0] aux_reference_divide, aux_program_count;
  logic [11:0] main_reference_divide, main_program_count;
  logic [15:0] aux_feedback_divide, main_feedback_divide, seed, d;
  logic        aux_pump_gain_bit, main_pump_gain_bit;
  logic        aux_detector_polarity_bit, main_detector_polarity_bit;
  logic [15:0] lat [4];
  int          fail_count = 0, checks_done = 0, cyc = 0;
  psl_latches DUT (.*);
  psl_host host (.*);
  always #2.5 sys_clk = ~sys_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ratio(input logic [11:0] b,
                                        input logic [3:0] a, input logic low);
    return (low ? {1'b0, b, 3'h0} : {b, 4'h0}) + {12'h0, a};
  endfunction
  task automatic check_all();
    logic [3:0] a;
    a = aux_low_option ? {1'b0, lat[1][2:0]} : lat[1][3:0];
    `CHK("sel", lat[0][15:12], multifunction_output_select)
    `CHK("aref", lat[0][11:0], aux_reference_divide)
    `CHK("aprog", lat[1][15:4], aux_program_count)
    `CHK("aswal", a, aux_swallow_count)
    `CHK("adiv", ratio(lat[1][15:4], a, aux_low_option), aux_feedback_divide)
    `CHK("pump", lat[2][15:12], pump_control_word)
    `CHK("bits", lat[2][15:12], {aux_pump_gain_bit, main_pump_gain_bit,
      aux_detector_polarity_bit, main_detector_polarity_bit})
    `CHK("mref", lat[2][11:0], main_reference_divide)
    `CHK("mprog", lat[3][15:4], main_program_count)
    `CHK("mswal", lat[3][3:0], main_swallow_count)
    `CHK("mdiv", ratio(lat[3][15:4], lat[3][3:0], 1'b0), main_feedback_divide)
    `CHK("loads", loads, load_count)
  endtask
  task automatic load(input logic [1:0] ad, input logic [15:0] w, input int n);
    host.send({seed[3:0], w, ad}, n);
    lat[ad] = w;
    loads = loads + 4'h1;
    @(negedge sys_clk);
    check_all();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    // x to 0 once all processes wait: the async resets see a fall
    resetn <= 1'h0;
    seed = 16'h0047;
    loads = 4'h0;
    foreach (lat[k]) lat[k] = '0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1;
    @(negedge sys_clk);
    check_all();
    load(ADDR_AUX_REF, 16'hf002, 18);
    load(ADDR_MAIN_REF, 16'hafff, 22);
    load(ADDR_AUX_FB, 16'h00ff, 18);
    @(posedge sys_clk) aux_low_option <= 1;
    load(ADDR_AUX_FB, 16'h007f, 22);
    load(ADDR_MAIN_FB, 16'hffff, 18);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      // ref divide kept at 2 or more, feedback program count at 16 or more
      d = seed | (seed[14] ? 16'h0100 : 16'h0002);
      if (seed[15:14] == ADDR_AUX_FB)
        @(posedge sys_clk) aux_low_option <= seed[8];
      load(seed[15:14], d, seed[5] ? 22 : 18);
    end
    @(posedge sys_clk) resetn <= 0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1;
    foreach (lat[k]) lat[k] = '0;
    loads = 4'h0;
    @(negedge sys_clk);
    check_all();
    load(ADDR_MAIN_FB, 16'h0123, 18);
    end_sim();
  end
endmodule
`default_nettype wire
